// *** rtl/power_switch_pkg.sv ***
// constants, types and event layout for the power switch controller
package power_switch_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ         = 50_000_000;
    localparam int DEBOUNCE_MS    = 15;
    localparam int DEGLITCH_US    = 3700;
    localparam int SOFT_START_US  = 1000;
    localparam int DEBOUNCE_CYC   = (DEBOUNCE_MS * (CLK_HZ / 1000));
    localparam int DEGLITCH_CYC   = (DEGLITCH_US * (CLK_HZ / 1_000_000));
    localparam int SOFT_START_CYC = (SOFT_START_US * (CLK_HZ / 1_000_000));
    localparam int TIMER_W        = 20;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam int         ADDR_W      = 4;
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_MASK   = 4'h8;
    localparam logic [3:0] ADDR_STATE  = 4'hc;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // event bits, shared by status and mask
    localparam int EV_W      = 5;
    localparam int EV_UV     = 0;
    localparam int EV_OV     = 1;
    localparam int EV_OT     = 2;
    localparam int EV_RCP    = 3;
    localparam int EV_PGOOD  = 4;
    localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

    // control bits
    localparam int CTRL_SW_OFF = 0;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SW_OFF,
        SW_DEBOUNCE,
        SW_SOFT_START,
        SW_ON
    } sw_state_e;

    // comparator flags from the analog side
    typedef struct packed {
        logic underVolt;     // input rail below undervoltage_threshold
        logic overDefault;   // input rail above fixed 23 V threshold
        logic overProg;      // input rail above programmed threshold
        logic threshLow;     // threshold-setting input below 0.1 V
        logic tempHot;       // die above 140 C
        logic tempCool;      // die below 115 C
        logic revSmall;      // output_rail above input by 45 mV
        logic revLarge;      // output_rail above input by 120 mV
    } comp_flags_s;

endpackage

// *** rtl/power_switch_protection_ctrl.sv ***
// load switch sequencer with protections and an AXI4-Lite register slave
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
module power_switch_protection_ctrl #(
    parameter int DEBOUNCE_CYCLES   = power_switch_pkg::DEBOUNCE_CYC,
    parameter int DEGLITCH_CYCLES   = power_switch_pkg::DEGLITCH_CYC,
    parameter int SOFT_START_CYCLES = power_switch_pkg::SOFT_START_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    // enable pin, active low, with its drive-presence sense
    input  wire logic                              enableN,
    input  wire logic                              enableDriven,
    // asynchronous comparator results
    input  wire power_switch_pkg::comp_flags_s     compFlags,
    // switch and status outputs
    output logic                                   switchOn,
    output logic                                   softStart,
    output logic                                   lowPower,
    output logic                                   powerGoodOut,
    output logic                                   powerGoodOe,
    output logic                                   irq,
    // AXI4-Lite slave
    input  wire logic [power_switch_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [power_switch_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready
);

    // ---------------------------------------------------------------
    // flag synchronisers
    // ---------------------------------------------------------------
    power_switch_pkg::comp_flags_s syncMeta;
    power_switch_pkg::comp_flags_s flags;

    // two-stage capture of every comparator flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta <= '0;
            flags    <= '0;
        end else begin
            syncMeta <= compFlags;
            flags    <= syncMeta;
        end
    end

    // ---------------------------------------------------------------
    // enable and fault decode
    // ---------------------------------------------------------------
    logic [power_switch_pkg::TIMER_W-1:0] timer;
    logic [power_switch_pkg::TIMER_W-1:0] rcpCount;
    logic                                 overTemp;
    logic                                 swOff;
    power_switch_pkg::sw_state_e          state;
    power_switch_pkg::sw_state_e          next_state;

    wire enActive    = ~enableN | ~enableDriven;
    wire overVolt    = flags.threshLow ? flags.overDefault
                                       : flags.overProg;
    wire deglitchEnd = (rcpCount
                        == power_switch_pkg::TIMER_W'(DEGLITCH_CYCLES - 1));
    wire rcpNow      = flags.revLarge
                     | (flags.revSmall & deglitchEnd);
    // undervoltage, overvoltage and heat only count while enabled
    wire enFault     = enActive
                     & (flags.underVolt | overVolt | overTemp);
    wire allowOn     = enActive & ~swOff & ~enFault & ~rcpNow;
    wire debounceEnd = (timer == power_switch_pkg::TIMER_W'(DEBOUNCE_CYCLES - 1));
    wire softEnd     = (timer == power_switch_pkg::TIMER_W'(SOFT_START_CYCLES - 1));

    // overtemperature with hysteresis, dropped while disabled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overTemp <= 1'b0;
        end else if (!enActive) begin
            overTemp <= 1'b0;
        end else if (flags.tempHot) begin
            overTemp <= 1'b1;
        end else if (flags.tempCool) begin
            overTemp <= 1'b0;
        end
    end

    // reverse deglitch counter, holds at its end while the gap persists
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcpCount <= '0;
        end else if (!flags.revSmall) begin
            rcpCount <= '0;
        end else if (!deglitchEnd) begin
            rcpCount <= rcpCount + 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // turn-on sequencer
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            power_switch_pkg::SW_OFF: begin
                if (allowOn && !flags.revSmall) begin
                    next_state = power_switch_pkg::SW_DEBOUNCE;
                end
            end
            power_switch_pkg::SW_DEBOUNCE: begin
                if (!allowOn || flags.revSmall) begin
                    next_state = power_switch_pkg::SW_OFF;
                end else if (debounceEnd) begin
                    next_state = power_switch_pkg::SW_SOFT_START;
                end
            end
            power_switch_pkg::SW_SOFT_START: begin
                if (!allowOn) begin
                    next_state = power_switch_pkg::SW_OFF;
                end else if (softEnd) begin
                    next_state = power_switch_pkg::SW_ON;
                end
            end
            power_switch_pkg::SW_ON: begin
                if (!allowOn) begin
                    next_state = power_switch_pkg::SW_OFF;
                end
            end
        endcase
    end

    wire stateChange = (next_state != state);
    wire nextConduct = (next_state == power_switch_pkg::SW_SOFT_START)
                     | (next_state == power_switch_pkg::SW_ON);

    // state, phase timer and switch drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= power_switch_pkg::SW_OFF;
            timer     <= '0;
            switchOn  <= 1'b0;
            softStart <= 1'b0;
            lowPower  <= 1'b0;
        end else begin
            state     <= next_state;
            timer     <= stateChange ? '0 : timer + 1'b1;
            switchOn  <= nextConduct;
            softStart <= (next_state == power_switch_pkg::SW_SOFT_START);
            lowPower  <= ~enActive;
        end
    end

    // open-drain power-good: pulls low only when fully on and fault-free
    wire next_pgood = (next_state == power_switch_pkg::SW_ON);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerGoodOut <= 1'b0;
            powerGoodOe  <= 1'b0;
        end else begin
            powerGoodOut <= 1'b0;
            powerGoodOe  <= next_pgood;
        end
    end

    // ---------------------------------------------------------------
    // events and interrupt
    // ---------------------------------------------------------------
    logic [power_switch_pkg::EV_W-1:0] status;
    logic [power_switch_pkg::EV_W-1:0] mask;
    logic [power_switch_pkg::EV_W-1:0] prevCond;
    logic [power_switch_pkg::EV_W-1:0] statusClr;

    wire [power_switch_pkg::EV_W-1:0] cond = {
        next_pgood, rcpNow, enActive & overTemp,
        enActive & overVolt, enActive & flags.underVolt};
    wire [power_switch_pkg::EV_W-1:0] evSet = cond & ~prevCond;
    wire [power_switch_pkg::EV_W-1:0] next_status =
        (status & ~statusClr) | evSet;             // set wins over clear

    // sticky status, edge detect and masked interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prevCond <= '0;
            status   <= '0;
            irq      <= 1'b0;
        end else begin
            prevCond <= cond;
            status   <= next_status;
            irq      <= |(next_status & mask);
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite write path
    // ---------------------------------------------------------------
    logic [power_switch_pkg::ADDR_W-1:0] awAddr;
    logic                                haveAw;
    logic [31:0]                         wData;
    logic [3:0]                          wStrb;
    logic                                haveW;

    wire awTake   = s_axi_awvalid & s_axi_awready;
    wire wTake    = s_axi_wvalid & s_axi_wready;
    wire bDone    = s_axi_bvalid & s_axi_bready;
    wire doWrite  = haveAw & haveW & ~s_axi_bvalid;
    wire wrCtrl   = doWrite & (awAddr == power_switch_pkg::ADDR_CTRL);
    wire wrMask   = doWrite & (awAddr == power_switch_pkg::ADDR_MASK);
    wire wrMapped = (awAddr == power_switch_pkg::ADDR_CTRL)
                  | (awAddr == power_switch_pkg::ADDR_MASK)
                  | (awAddr == power_switch_pkg::ADDR_STATUS)
                  | (awAddr == power_switch_pkg::ADDR_STATE);
    wire next_haveAw = (haveAw & ~doWrite) | awTake;
    wire next_haveW  = (haveW & ~doWrite) | wTake;
    wire next_bvalid = (s_axi_bvalid & ~bDone) | doWrite;

    // address and data channels latched independently
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awAddr        <= '0;
            haveAw        <= 1'b0;
            wData         <= '0;
            wStrb         <= '0;
            haveW         <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (awTake) begin
                awAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            haveAw        <= next_haveAw;
            haveW         <= next_haveW;
            s_axi_awready <= ~next_haveAw & ~next_bvalid;
            s_axi_wready  <= ~next_haveW & ~next_bvalid;
        end
    end

    // write response and writable registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= power_switch_pkg::RESP_OKAY;
            swOff        <= 1'b0;
            mask         <= power_switch_pkg::MASK_RESET;
        end else begin
            s_axi_bvalid <= next_bvalid;
            if (doWrite) begin
                s_axi_bresp <= wrMapped ? power_switch_pkg::RESP_OKAY
                                        : power_switch_pkg::RESP_SLVERR;
            end
            if (wrCtrl && wStrb[0]) begin
                swOff <= wData[power_switch_pkg::CTRL_SW_OFF];
            end
            if (wrMask && wStrb[0]) begin
                mask <= wData[power_switch_pkg::EV_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite read path
    // ---------------------------------------------------------------
    wire arTake  = s_axi_arvalid & s_axi_arready;
    wire rDone   = s_axi_rvalid & s_axi_rready;
    wire rdState = (s_axi_araddr == power_switch_pkg::ADDR_STATE);
    wire rdStat  = (s_axi_araddr == power_switch_pkg::ADDR_STATUS);
    wire rdMapped = rdState | rdStat
                  | (s_axi_araddr == power_switch_pkg::ADDR_CTRL)
                  | (s_axi_araddr == power_switch_pkg::ADDR_MASK);
    // live state: fsm, faults, pins
    wire [31:0] stateWord = {22'h000000, powerGoodOe, switchOn, rcpNow,
                             overTemp, overVolt, flags.underVolt, enActive,
                             lowPower, state};
    wire [31:0] rdWord =
        (s_axi_araddr == power_switch_pkg::ADDR_CTRL) ? {31'h00000000, swOff} :
        (s_axi_araddr == power_switch_pkg::ADDR_MASK) ? {27'h0000000, mask}   :
        rdStat                                        ? {27'h0000000, status} :
        rdState                                       ? stateWord             :
                                                        32'h00000000;

    // one read at a time; status cleared by its own read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= power_switch_pkg::RESP_OKAY;
            statusClr     <= '0;
        end else begin
            statusClr <= '0;
            if (arTake) begin
                s_axi_rdata   <= rdWord;
                s_axi_rresp   <= rdMapped ? power_switch_pkg::RESP_OKAY
                                          : power_switch_pkg::RESP_SLVERR;
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
                statusClr     <= rdStat ? status : '0;   // clear only what was reported
            end else if (rDone) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// *** tb/power_switch_protection_ctrl_sva.sv ***
// assertion checker for the power switch controller ports
module power_switch_protection_ctrl_sva #(
    parameter int DEBOUNCE_CYCLES   = 20,
    parameter int DEGLITCH_CYCLES   = 10,
    parameter int SOFT_START_CYCLES = 8
) (
    input wire logic                          clk,
    input wire logic                          rst_n,
    input wire logic                          enableN,
    input wire logic                          enableDriven,
    input wire power_switch_pkg::comp_flags_s compFlags,
    input wire logic                          switchOn,
    input wire logic                          softStart,
    input wire logic                          lowPower,
    input wire logic                          powerGoodOut,
    input wire logic                          powerGoodOe
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------
    // helper logic
    // --------------------------------------------------
    wire logic enAct = !enableN || !enableDriven;
    wire logic ovSel = compFlags.threshLow ? compFlags.overDefault : compFlags.overProg;
    wire logic anyBad = compFlags.underVolt | ovSel | compFlags.tempHot | compFlags.revSmall;
    int debCnt, ssCnt, revCnt;
    // clean enabled cycles before closing, ramp length, reverse persistence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debCnt <= 0;
            ssCnt  <= 0;
            revCnt <= 0;
        end else begin
            debCnt <= (enAct && !anyBad && !switchOn) ? debCnt + 1 : 0;
            ssCnt  <= softStart ? ssCnt + 1 : (switchOn ? ssCnt : 0);
            revCnt <= compFlags.revSmall ? revCnt + 1 : 0;
        end
    end
    // --------------------------------------------------
    // assertions
    // --------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence held5(logic c);
        c [*5];
    endsequence
    pg_needs_on_a: assert property (powerGoodOe |-> switchOn && !softStart && !powerGoodOut)
        else $error("power good while not conducting");
    ramp_gated_a: assert property (softStart |-> switchOn)
        else $error("ramp without switch");
    deb_length_a: assert property ($rose(switchOn) |-> softStart && debCnt >= DEBOUNCE_CYCLES)
        else $error("switch closed before debounce");
    ramp_length_a: assert property ($rose(powerGoodOe) |-> ssCnt == SOFT_START_CYCLES)
        else $error("ramp length wrong");
    disabled_open_a: assert property (held5(enableN && enableDriven) |-> !switchOn && lowPower)
        else $error("switch closed while disabled");
    undervolt_open_a: assert property (held5(enAct && compFlags.underVolt) |-> !switchOn && !powerGoodOe)
        else $error("switch closed in undervoltage");
    overvolt_open_a: assert property (held5(enAct && ovSel) |-> !switchOn && !powerGoodOe)
        else $error("switch closed in overvoltage");
    overtemp_open_a: assert property (held5(enAct && compFlags.tempHot) |-> !switchOn && !powerGoodOe)
        else $error("switch closed while hot");
    reverse_fast_a: assert property (held5(compFlags.revLarge) |-> !switchOn && !powerGoodOe)
        else $error("large reverse not tripped");
    reverse_slow_a: assert property (revCnt >= DEGLITCH_CYCLES + 4 |-> !switchOn)
        else $error("small reverse not tripped");
endmodule

bind power_switch_protection_ctrl power_switch_protection_ctrl_sva #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .DEGLITCH_CYCLES(DEGLITCH_CYCLES),
    .SOFT_START_CYCLES(SOFT_START_CYCLES)
) checker_i (
    .clk(clk), .rst_n(rst_n), .enableN(enableN), .enableDriven(enableDriven),
    .compFlags(compFlags), .switchOn(switchOn), .softStart(softStart), .lowPower(lowPower),
    .powerGoodOut(powerGoodOut), .powerGoodOe(powerGoodOe)
);

// *** tb/power_switch_protection_ctrl_tb.sv ***
// self-checking bench for the power switch controller
module power_switch_protection_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 20;
    localparam int GL  = 10;
    localparam int SS  = 8;
    logic        clk, rst_n, enableN, enableDriven, switchOn, softStart, lowPower, irq;
    logic        pgOut, pgOe, pgPin, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp;
    int          miscompares, checked, n;
    logic [7:0]  faultTab [4] = '{8'h84, 8'h24, 8'h54, 8'h08};
    logic [31:0] statTab [4]  = '{32'h11, 32'h12, 32'h12, 32'h14};
    power_switch_pkg::comp_flags_s flagsReq, compFlags;

    power_switch_protection_ctrl #(.DEBOUNCE_CYCLES(DEB), .DEGLITCH_CYCLES(GL),
        .SOFT_START_CYCLES(SS)) dut (
        .clk(clk), .rst_n(rst_n), .enableN(enableN), .enableDriven(enableDriven),
        .compFlags(compFlags), .switchOn(switchOn), .softStart(softStart),
        .lowPower(lowPower), .powerGoodOut(pgOut), .powerGoodOe(pgOe), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    usb_power_side side (.req(flagsReq), .compFlags(compFlags), .pgOut(pgOut), .pgOe(pgOe),
        .pgPin(pgPin));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // --------------------------------------------------
    // tasks
    // --------------------------------------------------
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic expire;
        miscompares++;
        $display("[ERR] %0t ns: wait ran out", $time);
        final_report();
    endtask
    task automatic axiWrite(input logic [3:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (k > 50) expire();
        end while (!bvalid);
        bready <= 1'b0;
        check(bresp, power_switch_pkg::RESP_OKAY);
    endtask
    task automatic axiRead(input logic [3:0] a);
        int k;
        k = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            k++;
            if (arready) arvalid <= 1'b0;
            if (k > 50) expire();
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask
    task automatic waitSw(input logic v);
        n = 0;
        while (switchOn !== v) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 400) expire();
        end
    endtask
    task automatic setF(input logic [7:0] f);
        @(posedge clk);
        flagsReq <= power_switch_pkg::comp_flags_s'(f);
    endtask
    task automatic turnOn;
        waitSw(1'b1);
        check(n >= DEB && n <= DEB + 6, 1'b1);
        check({softStart, pgPin}, 2'b11);
        repeat (SS + 2) @(posedge clk);
        #1;
        check({softStart, pgPin}, 2'b00);
    endtask
    task automatic turnOff;
        waitSw(1'b0);
        check({pgPin, softStart}, 2'b10);
    endtask
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial begin
        rst_n = 1'b0; enableN = 1'b1; enableDriven = 1'b1; flagsReq = 8'h04;
        awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'hf;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        miscompares = 0; checked = 0; n = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axiWrite(power_switch_pkg::ADDR_MASK, 32'h11);
        axiRead(power_switch_pkg::ADDR_MASK);
        check(d, 32'h11);
        check(rresp, power_switch_pkg::RESP_OKAY);
        axiRead(4'h2);
        check(d, 32'h0);
        check(rresp, power_switch_pkg::RESP_SLVERR);
        check({switchOn, lowPower, pgPin}, 3'b011);
        @(posedge clk);
        enableDriven <= 1'b0;
        turnOn();
        check(irq, 1'b1);
        axiRead(power_switch_pkg::ADDR_STATUS);
        check(d, 32'h10);
        repeat (2) @(posedge clk);
        #1;
        check(irq, 1'b0);
        $display("test undriven enable done");
        @(posedge clk);
        enableDriven <= 1'b1;
        turnOff();
        check(lowPower, 1'b1);
        @(posedge clk);
        enableN <= 1'b0;
        turnOn();
        $display("test enable toggle done");
        foreach (faultTab[i]) begin
            setF(faultTab[i]);
            turnOff();
            axiRead(power_switch_pkg::ADDR_STATUS);
            check(d, statTab[i]);
            if (i == 3) begin
                setF(8'h00);
                repeat (DEB + 10) @(posedge clk);
                #1;
                check(switchOn, 1'b0);
            end
            setF(8'h04);
            turnOn();
        end
        setF(8'h34);
        repeat (10) @(posedge clk);
        #1;
        check(switchOn, 1'b1);
        setF(8'h04);
        $display("test fault table done");
        setF(8'h06);
        repeat (GL - 4) @(posedge clk);
        setF(8'h04);
        repeat (6) @(posedge clk);
        #1;
        check(switchOn, 1'b1);
        setF(8'h06);
        waitSw(1'b0);
        check(n >= GL && n <= GL + 5, 1'b1);
        setF(8'h04);
        turnOn();
        setF(8'h07);
        waitSw(1'b0);
        check(n <= 4, 1'b1);
        @(posedge clk);
        enableN <= 1'b1;
        repeat (4) @(posedge clk);
        enableN <= 1'b0;
        repeat (DEB + 10) @(posedge clk);
        #1;
        check(switchOn, 1'b0);
        setF(8'h04);
        turnOn();
        $display("test reverse current done");
        @(posedge clk);
        enableN <= 1'b1;
        turnOff();
        @(posedge clk);
        enableN <= 1'b0;
        repeat (DEB / 2) @(posedge clk);
        setF(8'h06);
        setF(8'h04);
        turnOn();
        axiRead(power_switch_pkg::ADDR_STATE);
        check(d, 32'h30b);
        axiWrite(power_switch_pkg::ADDR_CTRL, 32'h1);
        turnOff();
        axiWrite(power_switch_pkg::ADDR_CTRL, 32'h0);
        turnOn();
        $display("test abort and soft disable done");
        final_report();
    end
endmodule

// *** tb/usb_power_side.sv ***
// far-side model: rail comparator flags and the pulled-up power-good pin
module usb_power_side (
    input  wire power_switch_pkg::comp_flags_s req,
    output power_switch_pkg::comp_flags_s      compFlags,
    input  wire logic                          pgOut,
    input  wire logic                          pgOe,
    output logic                               pgPin
);
    timeunit 1ns;
    timeprecision 1ps;
    // physical consistency of the comparator levels
    always_comb begin
        compFlags = req;
        compFlags.revSmall = req.revSmall | req.revLarge;
        compFlags.overProg = req.overProg | req.overDefault;
        compFlags.tempCool = req.tempCool & ~req.tempHot;
    end
    // external pull-up wins while the pin is released
    assign pgPin = pgOe ? pgOut : 1'b1;
endmodule
